// ==== board_supervisor.sv ====
/* board supervisor and test equipment model.
   assumes requests from the bench, changed after clock edges. */
`timescale 1ns/1ps
`default_nettype none
module board_supervisor #(
  parameter int SETTLE = 8
) (
  input  wire logic clk_in,
  input  wire logic hold_req_in,
  input  wire logic byp_req_in,
  input  wire logic trst_req_in,
  output logic      hard_reset_n_out,
  output logic      byp_sel_out,
  output logic      test_reset_out,
  output logic      test_clk_out
);
  int settle_q = 0;
  initial {hard_reset_n_out, byp_sel_out, test_reset_out} = 3'h0;
  always @(posedge clk_in) begin
    if (settle_q < SETTLE) settle_q <= settle_q + 1;
    hard_reset_n_out <= settle_q == SETTLE && !hold_req_in;
    byp_sel_out <= byp_req_in;
    test_reset_out <= trst_req_in === 1'b1;
  end
  assign test_clk_out = byp_sel_out & clk_in;
endmodule
`default_nettype wire

// ==== reset_and_test_clock_control.sv ====
/*
 * reset handling and core clock source selection of the controller core.
 * assumes the board supervisor drives hard_reset_n and test equipment the
 * test pins; the core clock mux itself is a glitch-free cell outside.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_and_test_clock_control
  import rst_pkg::*;
#(
  parameter int unsigned SEQ_CYCLES = rst_pkg::RESET_SEQ_CYC
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // reset pins and soft reset events
  input  wire logic        hard_reset_n_in,
  input  wire logic        sleep_exit_reset_in,
  input  wire logic        watchdog_reset_in,
  output logic             reset_indicator_out_n,
  // processor control
  output logic             abort_instr_out,
  output logic             cache_enable_allow_out,
  output logic             mmu_enable_allow_out,
  output logic             wbuf_enable_allow_out,
  output logic             idle_only_out,
  output logic             fetch_start_out,
  output logic [31:0]      fetch_addr_out,
  // test reset and clock bypass pins
  input  wire logic        core_clock_bypass_sel_in,
  input  wire logic        test_reset_in,
  output logic             core_clk_sel_ext_out,
  output logic             test_logic_enable_out
);
  // the sequence counter must reach SEQ_CYCLES - 1 without wrapping
  if (SEQ_CYCLES < 1 || SEQ_CYCLES >= (1 << SEQ_CNT_W)) begin : g_bad_seq_cycles
    $error("SEQ_CYCLES out of range");
  end

  typedef enum logic [2:0] {
    ST_HELD = 3'b001,
    ST_SEQ  = 3'b010,
    ST_RUN  = 3'b100
  } rst_state_e;

  logic hard_n_s;
  logic bypass_s;
  logic trst_s;

  sync_two_flop #(.RESET_VAL(1'b0)) u_sync_hard (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .async_in  (hard_reset_n_in),
    .sync_out  (hard_n_s)
  );

  // bypass and test reset are level pins from outside the clock domain;
  // both reset low, the level a floating test reset pin is pulled to
  logic [1:0] lvl_pin;
  logic [1:0] lvl_s;
  assign lvl_pin = {test_reset_in, core_clock_bypass_sel_in};
  for (genvar i = 0; i < 2; i = i + 1) begin : g_lvl_sync
    sync_two_flop #(.RESET_VAL(1'b0)) u_sync (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .async_in  (lvl_pin[i]),
      .sync_out  (lvl_s[i])
    );
  end
  assign bypass_s = lvl_s[0];
  assign trst_s   = lvl_s[1];

  rst_state_e           state_q;
  rst_state_e           state_d;
  logic [SEQ_CNT_W-1:0] cnt_q;
  logic [SEQ_CNT_W-1:0] cnt_d;
  logic                 ind_n_q;
  logic                 ind_n_d;
  logic                 abort_q;
  logic                 abort_d;
  logic                 allow_q;
  logic                 allow_d;
  logic                 idle_q;
  logic                 idle_d;
  logic                 start_q;
  logic                 start_d;
  logic [31:0]          addr_q;
  logic [31:0]          addr_d;
  logic                 sel_q;
  logic                 sel_d;
  logic                 ten_q;
  logic                 ten_d;
  logic                 soft_evt;

  always_comb begin
    soft_evt = sleep_exit_reset_in | watchdog_reset_in;
    state_d  = state_q;
    cnt_d    = cnt_q;
    start_d  = 1'b0;
    case (state_q)
      ST_HELD: begin
        cnt_d = '0;
        if (hard_n_s) begin
          state_d = ST_SEQ;
        end
      end
      ST_SEQ: begin
        cnt_d = cnt_q + 1'b1;
        if (!hard_n_s) begin
          state_d = ST_HELD;
        end else if (cnt_q == SEQ_CNT_W'(SEQ_CYCLES - 1)) begin
          state_d = ST_RUN;
          start_d = 1'b1;
        end
      end
      ST_RUN: begin
        if (!hard_n_s) begin
          state_d = ST_HELD;
        end else if (soft_evt) begin
          state_d = ST_SEQ;
          cnt_d   = '0;
        end
      end
      default: begin
        state_d = ST_HELD;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_HELD;
      cnt_q   <= '0;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      start_q <= start_d;
    end
  end

  // status outputs follow the next state, so they switch on the same edge
  // as the state and the restart pulse
  always_comb begin
    ind_n_d = 1'b0;
    abort_d = 1'b1;
    allow_d = 1'b0;
    idle_d  = 1'b1;
    addr_d  = RESTART_ADDR;
    if (state_d == ST_RUN) begin
      ind_n_d = 1'b1;
      allow_d = 1'b1;
      idle_d  = 1'b0;
    end
    // pin may fall asynchronously, so the raw synced level also aborts
    if (hard_n_s && state_d != ST_HELD) begin
      abort_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ind_n_q <= 1'b0;
      abort_q <= 1'b1;
      allow_q <= 1'b0;
      idle_q  <= 1'b1;
      addr_q  <= RESTART_ADDR;
    end else begin
      ind_n_q <= ind_n_d;
      abort_q <= abort_d;
      allow_q <= allow_d;
      idle_q  <= idle_d;
      addr_q  <= addr_d;
    end
  end

  // the core clock source follows the bypass pin only; test logic keeps its
  // own clock and reset, whatever the bypass select says
  always_comb begin
    sel_d = bypass_s;
    ten_d = trst_s;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sel_q <= 1'b0;
      ten_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      ten_q <= ten_d;
    end
  end

  assign reset_indicator_out_n  = ind_n_q;
  assign abort_instr_out        = abort_q;
  assign cache_enable_allow_out = allow_q;
  assign mmu_enable_allow_out   = allow_q;
  assign wbuf_enable_allow_out  = allow_q;
  assign idle_only_out          = idle_q;
  assign fetch_start_out        = start_q;
  assign fetch_addr_out         = addr_q;
  assign core_clk_sel_ext_out   = sel_q;
  assign test_logic_enable_out  = ten_q;  // test logic itself runs on its own test clock
endmodule
`default_nettype wire

// ==== reset_and_test_clock_control_tb.sv ====
/* random self-checking bench for the reset controller.
   assumes the supervisor model drives the reset and test pins. */
`timescale 1ns/1ps
`default_nettype none
module reset_and_test_clock_control_tb;
  import rst_pkg::*;
  logic clk_in = 1'b0, arst_n_in = 1'b0, sleep_exit_reset_in = 1'b0, watchdog_reset_in = 1'b0;
  logic hold = 1'b1, byp = 1'b0, trst = 1'b0;
  logic hard_reset_n_in, core_clock_bypass_sel_in, test_reset_in, reset_indicator_out_n, abort_instr_out;
  logic cache_enable_allow_out, mmu_enable_allow_out, wbuf_enable_allow_out, idle_only_out, fetch_start_out;
  logic core_clk_sel_ext_out, test_logic_enable_out;
  logic [31:0] fetch_addr_out, v, seed = 32'ha7ac;
  int n_errors = 0, n_tests = 0;
  wire [31:0] obs = {26'h0, reset_indicator_out_n, abort_instr_out, cache_enable_allow_out,
    mmu_enable_allow_out, wbuf_enable_allow_out, idle_only_out};
  always #20 clk_in = ~clk_in;
  board_supervisor i_sup (.clk_in(clk_in), .hold_req_in(hold), .byp_req_in(byp), .trst_req_in(trst),
    .hard_reset_n_out(hard_reset_n_in), .byp_sel_out(core_clock_bypass_sel_in),
    .test_reset_out(test_reset_in), .test_clk_out());
  localparam int SEQ = 10;
  reset_and_test_clock_control #(.SEQ_CYCLES(SEQ)) i_dut (.*);
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // held and running output patterns
  function logic [31:0] xp(input logic held);
    return held ? 32'h11 : 32'h2e;
  endfunction
  task give_verdict();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task wait_start(input int exp_k);
    int k;
    k = 0;
    while (fetch_start_out !== 1'b1 && k < 40) begin
      cyc(1);
      k++;
    end
    chk(k, exp_k);
    chk({31'h0, fetch_start_out}, 32'h1);
    chk(obs, xp(1'b0));
    chk(fetch_addr_out, RESTART_ADDR);
    cyc(1);
    chk({31'h0, fetch_start_out}, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (8) begin
      v = rnd();
      @(posedge clk_in);
      hold <= 1'b1;
      byp <= v[1];
      trst <= v[0];
      cyc(6 + v[5:2]);
      chk(obs, xp(1'b1));
      chk({30'h0, core_clk_sel_ext_out, test_logic_enable_out}, {30'h0, v[1:0]});
      @(posedge clk_in);
      hold <= 1'b0;
      wait_start(SEQ + 4);
      repeat (v[7:6] + 1) @(posedge clk_in);
      if (v[8]) sleep_exit_reset_in <= 1'b1;
      else watchdog_reset_in <= 1'b1;
      @(posedge clk_in);
      sleep_exit_reset_in <= 1'b0;
      watchdog_reset_in <= 1'b0;
      #1;
      chk({31'h0, reset_indicator_out_n}, 32'h0);
      wait_start(SEQ);
    end
    give_verdict();
  end
  initial begin
    #(40 * 3000);
    n_errors++;
    $display("ERROR %0t timeout", $time);
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== rst_pkg.sv ====
/*
 * constants shared by the reset and test clock controller.
 * assumes a single core clock at 25 MHz.
 */
package rst_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  // reset sequence length after hard reset release, in ns
  localparam int unsigned RESET_SEQ_NS    = 400;
  localparam int unsigned RESET_SEQ_CYC   = (RESET_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SEQ_CNT_W       = 8;
  localparam logic [31:0] RESTART_ADDR    = 32'h0000_0000;
  localparam int unsigned SYNC_STAGES     = 2;
endpackage

// ==== rtc_chk_assertions.sv ====
/* checker on the reset controller ports.
   assumes a bind to the controller with port names kept. */
`timescale 1ns/1ps
`default_nettype none
module rtc_chk (
  // watched ports
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic hard_reset_n_in,
  input wire logic sleep_exit_reset_in,
  input wire logic watchdog_reset_in,
  input wire logic reset_indicator_out_n,
  input wire logic abort_instr_out,
  input wire logic cache_enable_allow_out,
  input wire logic idle_only_out,
  input wire logic fetch_start_out,
  input wire logic core_clock_bypass_sel_in,
  input wire logic core_clk_sel_ext_out,
  input wire logic test_reset_in,
  input wire logic test_logic_enable_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  chk_hold_abort: assert property (!hard_reset_n_in[*4] |-> abort_instr_out && !cache_enable_allow_out)
    else $error("abort missing");
  chk_hold_idle: assert property (!hard_reset_n_in[*4] |-> idle_only_out)
    else $error("idle missing");
  chk_hold_ind: assert property (!hard_reset_n_in[*4] |-> !reset_indicator_out_n)
    else $error("indicator high in reset");
  chk_start_seq: assert property ($rose(hard_reset_n_in) |-> !fetch_start_out[*3] ##[1:17] fetch_start_out)
    else $error("restart timing");
  chk_start_ind: assert property (fetch_start_out |-> $rose(reset_indicator_out_n))
    else $error("indicator release");
  chk_soft_ind: assert property (hard_reset_n_in[*3] ##0 reset_indicator_out_n &&
    (sleep_exit_reset_in || watchdog_reset_in) |=> !reset_indicator_out_n) else $error("soft reset missed");
  chk_bypass_sel: assert property ($stable(core_clock_bypass_sel_in)[*4] |->
    core_clk_sel_ext_out == core_clock_bypass_sel_in) else $error("clock select");
  chk_test_en: assert property ($stable(test_reset_in)[*4] |-> test_logic_enable_out == test_reset_in)
    else $error("test enable");
endmodule
bind reset_and_test_clock_control rtc_chk i_chk (.*);
`default_nettype wire

// ==== sync_two_flop.sv ====
/*
 * two flip-flop synchroniser for one level, with a settable reset value.
 * assumes the input is asynchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  // level
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire
